/* File: pdrc_defines.svh */
// Timing counts, bit positions and reset values of the power-down and
// reset controller. Assumes a 10 MHz system clock.
`ifndef PDRC_DEFINES_SVH
`define PDRC_DEFINES_SVH

`define PDRC_CLK_PERIOD_NS      100
`define PDRC_POST_RESET_NS      120
`define PDRC_POST_RESET_CYC     \
  ((`PDRC_POST_RESET_NS / `PDRC_CLK_PERIOD_NS) < 1 ? 1 : \
   (`PDRC_POST_RESET_NS / `PDRC_CLK_PERIOD_NS))
`define PDRC_WARM_RESET_NS      150
`define PDRC_WARM_RESET_CYC     \
  ((`PDRC_WARM_RESET_NS + `PDRC_CLK_PERIOD_NS - 1) / `PDRC_CLK_PERIOD_NS)
`define PDRC_FLASH_ABORT_US     25
`define PDRC_FLASH_ABORT_CYC    \
  ((`PDRC_FLASH_ABORT_US * 1000) / `PDRC_CLK_PERIOD_NS)

`define PDRC_IDLE_LIMIT         4'hF
`define PDRC_CFG_LOAD_DEFAULT   8

`define PDRC_PMA_AND_CLK_BIT    4
`define PDRC_PMA_MC_CLK_BIT     5
`define PDRC_PMC_LOW_ADDR_BIT   0
`define PDRC_PMC_CTRL0_BIT      2
`define PDRC_PMC_CTRL1_BIT      3
`define PDRC_PMC_CTRL2_BIT      4
`define PDRC_PMC_STROBE_BIT     5
`define PDRC_PMC_WR_HIGH_BIT    6
`define PDRC_PM_RESET           8'h00

`define PDRC_MM_SRAM_CODE_BIT   0
`define PDRC_MM_PERIPH_BIT      7
`define PDRC_MM_FORCE_MASK      8'h81

`endif

/* File: pdrc_pkg.sv */
// Types shared by the power-down and reset controller and its macrocells.
// Assumes the constants header is compiled alongside.
package pdrc_pkg;
  localparam int MC_COUNT = 16;

  typedef enum logic [2:0] {
    FL_READ    = 3'h1,
    FL_PROGRAM = 3'h2,
    FL_ERASE   = 3'h4
  } pdrc_flash_t;

  typedef logic [MC_COUNT-1:0] pdrc_mcvec_t;
endpackage

/* File: pdrc_mc_if.sv */
// Bundle between the controller and its output macrocell bank.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface pdrc_mc_if;
  import pdrc_pkg::*;
  logic        porClear;
  logic        clkEnable;
  pdrc_mcvec_t dataIn;
  pdrc_mcvec_t resetEq;
  pdrc_mcvec_t presetEq;
  pdrc_mcvec_t q;

  modport ctrl (output porClear, output clkEnable, output dataIn,
                output resetEq, output presetEq, input q);
  modport bank (input porClear, input clkEnable, input dataIn,
                input resetEq, input presetEq, output q);
endinterface

/* File: pdrc_macrocells.sv */
// Output macrocell flip-flop bank of the programmable logic.
// Assumes the clock enable already carries the gated logic-clock edge.
`timescale 1ns/1ps
module pdrc_macrocells (
  input  wire logic clk_sys,
  input  wire logic ce,
  pdrc_mc_if.bank   mc
);
  import pdrc_pkg::*;

  typedef struct packed {
    pdrc_mcvec_t q;
  } pdrc_mc_state_t;

  pdrc_mc_state_t st;
  pdrc_mc_state_t next_st;
  pdrc_mcvec_t    next_q;

  genvar i;
  generate
    for (i = 0; i < MC_COUNT; i++) begin : g_cell
      // Reset equation outranks preset, as a clear usually must win.
      always_comb begin
        if (mc.porClear) begin
          next_q[i] = 1'b0; // RL19
        end else if (mc.resetEq[i]) begin
          next_q[i] = 1'b0; // RL19
        end else if (mc.presetEq[i]) begin
          next_q[i] = 1'b1; // RL19
        end else if (mc.clkEnable) begin
          next_q[i] = mc.dataIn[i];
        end else begin
          next_q[i] = st.q[i];
        end
      end
    end
  endgenerate

  always_comb begin
    next_st   = st;
    next_st.q = next_q;
  end

  always_ff @(posedge clk_sys) begin
    if (ce) begin
      st <= next_st;
    end
  end

  assign mc.q = st.q;
endmodule

/* File: pdrc_top.sv */
// Power-down and reset controller: memory select gating, logic input
// gating, idle power-down, reset sequencing and flash cycle abort.
// Assumes pins arrive asynchronously and rst_n is already on clk_sys.
// Function
// RL1: Chip select low enables memories and I/O.
// RL2: Chip select high deselects flashes and SRAM.
// RL3: Mode register A bits gate logic clock.
// RL4: Mode register C bits block address, controls.
// RL5: Idle strobe for fifteen clocks enters power-down.
// RL6: Strobe pulse, chip select, reset end power-down.
// RL7: Power-down blocks bus and deselects memories.
// RL8: Idle counter always sees the logic clock.
// RL9: Host holds power-on reset one millisecond.
// RL10: Power-on reset loads configuration, clears registers.
// RL11: No memory access shortly after reset release.
// RL12: Flash controller starts in read mode.
// RL13: Host keeps selects low, write high.
// RL14: Lockout refuses any flash write start.
// RL15: Warm reset gets same post-release delay.
// RL16: Logic outputs valid through warm reset.
// RL17: Reset aborts flash cycle back to read.
// RL18: Power-down port states follow the table.
// RL19: Power-on clears macrocells; else equations apply.
// RL20: Reset reloads memory map, forcing two bits.
// RL21: Battery-on indicator, routable to a port pin.
// RL22: Mode registers cleared only by power-on.
`timescale 1ns/1ps
`include "pdrc_defines.svh"
module pdrc_top #(
  parameter int CFG_LOAD_CYC = `PDRC_CFG_LOAD_DEFAULT
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire logic                 powerOnActive,
  input  wire logic                 addressStrobe,
  input  wire logic                 chipSelect_n,
  input  wire logic                 logicInputClock,
  input  wire logic                 writeLockout,
  input  wire logic                 mainBelowStandby,
  input  wire logic                 autoPowerDownEnable,
  input  wire logic                 strobeIdlePolarity,
  input  wire logic                 pmWrite,
  input  wire logic                 pmSelectC,
  input  wire logic [7:0]           pmWriteData,
  input  wire logic                 mmWrite,
  input  wire logic [7:0]           mmWriteData,
  input  wire logic [7:0]           memMapConfig,
  input  wire logic [7:0]           lowAddress,
  input  wire logic                 busControl0,
  input  wire logic                 busControl1,
  input  wire logic                 busControl2,
  input  wire logic                 writeHighByteStrobe,
  input  wire logic                 flashProgramStart,
  input  wire logic                 flashEraseStart,
  input  wire logic                 flashOpDone,
  input  wire logic                 batteryRouteEnable,
  input  wire pdrc_pkg::pdrc_mcvec_t mcDataIn,
  input  wire pdrc_pkg::pdrc_mcvec_t mcResetEq,
  input  wire pdrc_pkg::pdrc_mcvec_t mcPresetEq,
  output logic                      primaryFlashSelect,
  output logic                      secondaryFlashSelect,
  output logic                      sramSelect,
  output logic                      ioSelect,
  output logic                      busBlocked,
  output logic                      powerDownFlag,
  output logic                      resetMode,
  output logic                      pldOutputsValid,
  output logic                      andArrayClock,
  output logic                      macrocellClockEnable,
  output logic [7:0]                pldLowAddress,
  output logic                      pldBusControl0,
  output logic                      pldBusControl1,
  output logic                      pldBusControl2,
  output logic                      pldAddressStrobe,
  output logic                      pldWriteHighByte,
  output logic [7:0]                powerModeRegA,
  output logic [7:0]                powerModeRegC,
  output logic [7:0]                memoryMapRegister,
  output pdrc_pkg::pdrc_flash_t     flashState,
  output logic                      flashReadMode,
  output logic                      mcuIoInputMode,
  output logic                      mcuIoHold,
  output logic                      dataPortOe,
  output logic                      peripheralOe,
  output logic                      addressOutOe,
  output logic                      batteryOnIndicator,
  output logic                      portEPin7Out,
  output logic                      portEPin7Oe,
  output pdrc_pkg::pdrc_mcvec_t     mcOutputs
);
  import pdrc_pkg::*;

  localparam logic [1:0] POST_CYC = 2'(`PDRC_POST_RESET_CYC);
  localparam logic [7:0] CFG_CYC  = 8'(CFG_LOAD_CYC);

  typedef struct packed {
    logic [2:0]  strobeSync;
    logic [2:0]  csSync;
    logic [2:0]  lclkSync;
    logic [2:0]  lockSync;
    logic [2:0]  battSync;
    logic [2:0]  porSync;
    logic        strobeFilt;
    logic        strobePrev;
    logic        csFilt_n;
    logic        lclkFilt;
    logic        lclkPrev;
    logic        lockFilt;
    logic        battFilt;
    logic        porFilt;
    logic [3:0]  idleCount;
    logic        powerDown;
    logic [7:0]  pmA;
    logic [7:0]  pmC;
    logic [7:0]  memMap;
    pdrc_flash_t flash;
    logic [1:0]  postCount;
    logic        inReset;
    logic        cfgLoaded;
    logic [7:0]  cfgCount;
    logic [7:0]  pldAddr;
    logic [4:0]  pldCtrl;
    logic        andClk;
  } pdrc_state_t;

  pdrc_state_t st;
  pdrc_state_t next_st;

  logic strobeEdge;
  logic lclkRise;
  logic memAllowed;
  logic addrBlock;

  pdrc_mc_if mcBus ();

  // The first synchroniser stage feeds only the next stage; the filter looks at
  // stages two and three and takes a new level only when they agree.
  function automatic logic filt3(input logic [2:0] s, input logic cur);
    filt3 = (s[1] == s[2]) ? s[1] : cur;
  endfunction

  assign strobeEdge = st.strobeFilt != st.strobePrev;
  assign lclkRise   = st.lclkFilt & ~st.lclkPrev;
  assign memAllowed = rst_n & ~st.inReset & ~st.powerDown;
  assign addrBlock  = st.powerDown | st.pmC[`PDRC_PMC_LOW_ADDR_BIT];

  always_comb begin
    next_st = st;
    next_st.strobeSync = {st.strobeSync[1:0], addressStrobe};
    next_st.csSync     = {st.csSync[1:0], chipSelect_n};
    next_st.lclkSync   = {st.lclkSync[1:0], logicInputClock};
    next_st.lockSync   = {st.lockSync[1:0], writeLockout};
    next_st.battSync   = {st.battSync[1:0], mainBelowStandby};
    next_st.porSync    = {st.porSync[1:0], powerOnActive};
    next_st.strobeFilt = filt3(st.strobeSync, st.strobeFilt);
    next_st.csFilt_n   = filt3(st.csSync, st.csFilt_n);
    next_st.lclkFilt   = filt3(st.lclkSync, st.lclkFilt);
    next_st.lockFilt   = filt3(st.lockSync, st.lockFilt);
    next_st.battFilt   = filt3(st.battSync, st.battFilt);
    next_st.porFilt    = filt3(st.porSync, st.porFilt);
    next_st.strobePrev = st.strobeFilt;
    next_st.lclkPrev   = st.lclkFilt;

    // Logic inputs are gated in this cycle so the array sees them late
    // by one clock; cheaper than a combinational path through the pins.
    next_st.pldAddr = addrBlock ? 8'h00 : lowAddress; // RL4 RL7 RL18
    next_st.pldCtrl[0] = busControl0 & ~st.pmC[`PDRC_PMC_CTRL0_BIT]; // RL4
    next_st.pldCtrl[1] = busControl1 & ~st.pmC[`PDRC_PMC_CTRL1_BIT]; // RL4
    next_st.pldCtrl[2] = busControl2 & ~st.pmC[`PDRC_PMC_CTRL2_BIT]; // RL4
    next_st.pldCtrl[3] = st.strobeFilt & ~st.pmC[`PDRC_PMC_STROBE_BIT]; // RL4
    next_st.pldCtrl[4] = writeHighByteStrobe &
                         ~st.pmC[`PDRC_PMC_WR_HIGH_BIT]; // RL4
    next_st.andClk = st.lclkFilt & ~st.pmA[`PDRC_PMA_AND_CLK_BIT]; // RL3

    if (!rst_n) begin
      next_st.idleCount = 4'h0;
      next_st.powerDown = 1'b0; // RL6
      next_st.flash     = FL_READ; // RL17 RL12
      next_st.inReset   = 1'b1;
      next_st.postCount = POST_CYC; // RL11 RL15
      next_st.memMap    = memMapConfig & ~`PDRC_MM_FORCE_MASK; // RL20
      if (st.porFilt) begin
        next_st.pmA = `PDRC_PM_RESET; // RL22 RL10
        next_st.pmC = `PDRC_PM_RESET; // RL22 RL10
        if (st.cfgCount < CFG_CYC) begin
          next_st.cfgCount = st.cfgCount + 8'h01; // RL10
        end
        next_st.cfgLoaded = st.cfgCount >= CFG_CYC; // RL16
      end else begin
        // Warm reset keeps the load state; the count restarts so that a
        // later power-on load never begins from a stale value.
        next_st.cfgCount = 8'h00;
      end
    end else begin
      if (st.porFilt) begin
        // Supply monitor still busy: configuration restarts next reset.
        next_st.cfgCount = 8'h00;
      end
      if (st.inReset) begin
        if (st.postCount > 2'h1) begin
          next_st.postCount = st.postCount - 2'h1; // RL11
        end else begin
          next_st.inReset = 1'b0; // RL11 RL15
        end
      end

      // Idle counter runs on the filtered pin clock, ahead of any
      // mode-register gating of that clock.
      if (!autoPowerDownEnable || strobeEdge || !st.csFilt_n) begin
        next_st.idleCount = 4'h0; // RL5 RL6
        next_st.powerDown = 1'b0; // RL6
      end else if (st.strobeFilt == strobeIdlePolarity) begin
        if (lclkRise && st.idleCount != `PDRC_IDLE_LIMIT) begin // RL8
          next_st.idleCount = st.idleCount + 4'h1; // RL5
        end
        if (lclkRise && st.idleCount == `PDRC_IDLE_LIMIT - 4'h1) begin
          next_st.powerDown = 1'b1; // RL5
        end
      end else begin
        next_st.idleCount = 4'h0; // RL5
      end

      if (pmWrite) begin
        if (pmSelectC) begin
          next_st.pmC = pmWriteData; // RL4
        end else begin
          next_st.pmA = pmWriteData; // RL3
        end
      end
      if (mmWrite) begin
        next_st.memMap = mmWriteData;
      end

      case (st.flash)
        FL_READ: begin
          // Starts need a selected, awake device out of reset mode.
          if (!st.lockFilt && memAllowed && !st.csFilt_n) begin // RL14
            if (flashProgramStart) begin
              next_st.flash = FL_PROGRAM;
            end else if (flashEraseStart) begin
              next_st.flash = FL_ERASE;
            end
          end
        end
        FL_PROGRAM: begin
          if (flashOpDone) begin
            next_st.flash = FL_READ;
          end
        end
        FL_ERASE: begin
          if (flashOpDone) begin
            next_st.flash = FL_READ;
          end
        end
        default: begin
          next_st.flash = FL_READ;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (ce) begin
      st <= next_st;
    end
  end

  assign mcBus.porClear  = ~rst_n & st.porFilt; // RL19
  assign mcBus.clkEnable = lclkRise & ~st.pmA[`PDRC_PMA_MC_CLK_BIT]; // RL3
  assign mcBus.dataIn    = mcDataIn;
  // Equations keep working through warm reset and power-down.
  assign mcBus.resetEq   = mcResetEq; // RL19
  assign mcBus.presetEq  = mcPresetEq; // RL19

  pdrc_macrocells u_macrocells (
    .clk_sys (clk_sys),
    .ce      (ce),
    .mc      (mcBus.bank)
  );

  assign primaryFlashSelect   = memAllowed & ~st.csFilt_n; // RL1 RL2 RL7
  assign secondaryFlashSelect = memAllowed & ~st.csFilt_n; // RL1 RL2 RL7
  assign sramSelect           = memAllowed & ~st.csFilt_n; // RL1 RL2 RL7
  // I/O keeps working while chip select is high.
  assign ioSelect             = rst_n & ~st.inReset & ~st.powerDown; // RL2
  assign busBlocked           = st.powerDown; // RL7
  assign powerDownFlag        = st.powerDown;
  assign resetMode            = st.inReset;
  assign pldOutputsValid      = st.cfgLoaded; // RL16
  assign andArrayClock        = st.andClk;
  assign macrocellClockEnable = ~st.pmA[`PDRC_PMA_MC_CLK_BIT];
  assign pldLowAddress        = st.pldAddr;
  assign pldBusControl0       = st.pldCtrl[0];
  assign pldBusControl1       = st.pldCtrl[1];
  assign pldBusControl2       = st.pldCtrl[2];
  assign pldAddressStrobe     = st.pldCtrl[3];
  assign pldWriteHighByte     = st.pldCtrl[4];
  assign powerModeRegA        = st.pmA;
  assign powerModeRegC        = st.pmC;
  assign memoryMapRegister    = st.memMap;
  assign flashState           = st.flash;
  assign flashReadMode        = st.flash == FL_READ; // RL12
  assign mcuIoInputMode       = st.inReset;
  assign mcuIoHold            = st.powerDown; // RL18
  assign dataPortOe           = memAllowed; // RL18
  assign peripheralOe         = memAllowed; // RL18
  // Address-out is undefined in power-down; it simply keeps driving.
  assign addressOutOe         = rst_n & ~st.inReset; // RL18
  assign batteryOnIndicator   = st.battFilt; // RL21
  assign portEPin7Out         = st.battFilt; // RL21
  assign portEPin7Oe          = batteryRouteEnable; // RL21
  assign mcOutputs            = mcBus.q;
endmodule

/* File: pdrc_properties.sv */
// Concurrent checks on the power-down and reset controller's ports.
// Assumes ce stays high and pins are held long enough to pass the filters.
`timescale 1ns/1ps
module pdrc_properties #(
  parameter int CFG_LOAD_CYC = 8
) (
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  input wire logic                 powerOnActive,
  input wire logic                 chipSelect_n,
  input wire logic                 writeLockout,
  input wire logic [7:0]           memMapConfig,
  input wire logic                 primaryFlashSelect,
  input wire logic                 secondaryFlashSelect,
  input wire logic                 sramSelect,
  input wire logic                 ioSelect,
  input wire logic                 busBlocked,
  input wire logic                 powerDownFlag,
  input wire logic                 resetMode,
  input wire logic                 andArrayClock,
  input wire logic [7:0]           pldLowAddress,
  input wire logic [7:0]           powerModeRegA,
  input wire logic [7:0]           powerModeRegC,
  input wire logic [7:0]           memoryMapRegister,
  input wire pdrc_pkg::pdrc_flash_t flashState
);
  import pdrc_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  property p_cs_low;
    disable iff (!rst_n)
      (!chipSelect_n) [*6] ##0 ioSelect |->
        primaryFlashSelect && sramSelect;
  endproperty
  a_cs_low: assert property (p_cs_low)
    else $error("memory not selected");
  property p_cs_high;
    disable iff (!rst_n) chipSelect_n [*6] |->
      !primaryFlashSelect && !secondaryFlashSelect && !sramSelect;
  endproperty
  a_cs_high: assert property (p_cs_high)
    else $error("memory selected");
  property p_pd_block;
    disable iff (!rst_n) powerDownFlag |->
      busBlocked && !sramSelect && !primaryFlashSelect;
  endproperty
  a_pd_block: assert property (p_pd_block)
    else $error("bus open in power-down");
  property p_clk_gate;
    disable iff (!rst_n)
      powerModeRegA[4] && $past(powerModeRegA[4]) |-> !andArrayClock;
  endproperty
  a_clk_gate: assert property (p_clk_gate)
    else $error("logic clock not gated");
  property p_addr_gate;
    disable iff (!rst_n) powerModeRegC[0] [*3] |-> $stable(pldLowAddress);
  endproperty
  a_addr_gate: assert property (p_addr_gate)
    else $error("low address not gated");
  property p_post_rst;
    disable iff (!rst_n)
      $rose(rst_n) |-> resetMode && !primaryFlashSelect ##1 !resetMode;
  endproperty
  a_post_rst: assert property (p_post_rst)
    else $error("post-reset window wrong");
  property p_rst_read;
    !rst_n |=> flashState == FL_READ;
  endproperty
  a_rst_read: assert property (p_rst_read)
    else $error("flash not back in read");
  property p_mm_reload;
    !rst_n |=> memoryMapRegister == ($past(memMapConfig) & 8'h7E);
  endproperty
  a_mm_reload: assert property (p_mm_reload)
    else $error("map not reloaded");
  property p_lockout;
    disable iff (!rst_n)
      (flashState == FL_READ && writeLockout) [*6] |=>
        flashState == FL_READ;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("write started in lockout");
  c_pd: cover property (powerDownFlag);
  c_prog: cover property (flashState == FL_PROGRAM);
  c_warm: cover property ($rose(rst_n) && !powerOnActive);
endmodule
bind pdrc_top pdrc_properties #(.CFG_LOAD_CYC(CFG_LOAD_CYC)) chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .powerOnActive(powerOnActive),
  .chipSelect_n(chipSelect_n), .writeLockout(writeLockout),
  .memMapConfig(memMapConfig), .primaryFlashSelect(primaryFlashSelect),
  .secondaryFlashSelect(secondaryFlashSelect), .sramSelect(sramSelect),
  .ioSelect(ioSelect), .busBlocked(busBlocked), .powerDownFlag(powerDownFlag),
  .resetMode(resetMode), .andArrayClock(andArrayClock),
  .pldLowAddress(pldLowAddress), .powerModeRegA(powerModeRegA),
  .powerModeRegC(powerModeRegC), .memoryMapRegister(memoryMapRegister),
  .flashState(flashState));

/* File: pdrc_mcu_model.sv */
// Host side model: address strobe, chip select, logic clock, write strobe.
// Assumes the bench changes its run controls just after a clk_sys edge.
`timescale 1ns/1ps
module pdrc_mcu_model (
  input  wire logic clk_sys,
  input  wire logic clkRun,
  input  wire logic strobeRun,
  input  wire logic strobeIdle,
  input  wire logic csActive,
  output logic      addressStrobe,
  output logic      logicInputClock,
  output logic      chipSelect_n,
  output logic      writeStrobe
);
  logic [2:0] div;
  initial begin
    div = 3'h0;
    addressStrobe = 1'b0;
    logicInputClock = 1'b0;
  end
  // Slow edges so that the three-stage pin filters see every level.
  always @(posedge clk_sys) begin
    div <= div + 3'h1;
    if (clkRun) begin
      logicInputClock <= div[2];
    end
    if (!strobeRun) begin
      addressStrobe <= strobeIdle;
    end else if (div == 3'h0) begin
      addressStrobe <= ~addressStrobe;
    end
  end
  assign chipSelect_n = ~csActive;
  assign writeStrobe = 1'b1;
endmodule

/* File: power_down_and_reset_control_tb.sv */
// Self-checking bench for pdrc_top with the host model on its pins.
// Assumes a shortened configuration load count of two cycles.
`timescale 1ns/1ps
module power_down_and_reset_control_tb;
  import pdrc_pkg::*;
  logic clk_sys, rst_n, powerOnActive, writeLockout, mainBelowStandby;
  logic autoPowerDownEnable, strobeIdlePolarity, pmWrite, pmSelectC, mmWrite;
  logic pldBusControl0, pldBusControl1, pldBusControl2, pldAddressStrobe;
  logic busControl1, busControl2, writeHighByteStrobe, flashOpDone;
  logic flashProgramStart, flashEraseStart, batteryRouteEnable;
  logic [7:0] pmWriteData, mmWriteData, memMapConfig, lowAddress;
  logic [7:0] pldLowAddress, powerModeRegA, powerModeRegC, memoryMapRegister;
  pdrc_mcvec_t mcDataIn, mcResetEq, mcPresetEq, mcOutputs;
  logic addressStrobe, logicInputClock, chipSelect_n, busControl0;
  logic clkRun, strobeRun, strobeIdle, csActive;
  logic primaryFlashSelect, secondaryFlashSelect, sramSelect, ioSelect;
  logic busBlocked, powerDownFlag, resetMode, pldOutputsValid, andArrayClock;
  logic macrocellClockEnable, flashReadMode, mcuIoInputMode, mcuIoHold;
  logic dataPortOe, peripheralOe, addressOutOe, batteryOnIndicator;
  logic portEPin7Out, portEPin7Oe, pldWriteHighByte;
  pdrc_flash_t flashState;
  int errCount = 0;
  int comparisons = 0;
  int cycles = 0;
  pdrc_mcu_model mcu_u (.clk_sys, .clkRun, .strobeRun, .strobeIdle, .csActive,
    .addressStrobe, .logicInputClock, .chipSelect_n, .writeStrobe(busControl0));
  pdrc_top #(.CFG_LOAD_CYC(2)) dut_u (
    .clk_sys, .rst_n, .ce(1'b1), .powerOnActive, .addressStrobe, .chipSelect_n,
    .logicInputClock, .writeLockout, .mainBelowStandby, .autoPowerDownEnable,
    .strobeIdlePolarity, .pmWrite, .pmSelectC, .pmWriteData, .mmWrite,
    .mmWriteData, .memMapConfig, .lowAddress, .busControl0, .busControl1,
    .busControl2, .writeHighByteStrobe, .flashProgramStart, .flashEraseStart,
    .flashOpDone, .batteryRouteEnable, .mcDataIn, .mcResetEq, .mcPresetEq,
    .primaryFlashSelect, .secondaryFlashSelect, .sramSelect, .ioSelect,
    .busBlocked, .powerDownFlag, .resetMode, .pldOutputsValid, .andArrayClock,
    .macrocellClockEnable, .pldLowAddress, .pldBusControl0,
    .pldBusControl1, .pldBusControl2, .pldAddressStrobe,
    .pldWriteHighByte, .powerModeRegA, .powerModeRegC, .memoryMapRegister,
    .flashState, .flashReadMode, .mcuIoInputMode, .mcuIoHold, .dataPortOe,
    .peripheralOe, .addressOutOe, .batteryOnIndicator, .portEPin7Out,
    .portEPin7Oe, .mcOutputs);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      errCount++;
      summarize;
    end
  end
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Looks just after the edge so that the edge's updates have landed.
  task check(input logic seen, input logic exp);
    #1;
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task wr(input logic toMap, input logic regC, input logic [7:0] d);
    @(posedge clk_sys);
    {mmWrite, pmWrite, pmSelectC} <= {toMap, !toMap, regC};
    {mmWriteData, pmWriteData} <= {d, d};
    @(posedge clk_sys);
    {mmWrite, pmWrite} <= 2'h0;
  endtask
  task fl(input logic [2:0] p);
    @(posedge clk_sys);
    {flashProgramStart, flashEraseStart, flashOpDone} <= p;
    @(posedge clk_sys);
    {flashProgramStart, flashEraseStart, flashOpDone} <= 3'h0;
  endtask
  // Pulses the strobe to clear the count, then rests it for n clock rises.
  task idle(input logic lvl, input logic en, input int n, input logic exp);
    @(posedge clk_sys);
    {strobeRun, autoPowerDownEnable} <= {1'b1, en};
    tick(24);
    check(powerDownFlag, 1'b0);
    @(posedge clk_sys);
    {strobeRun, strobeIdle} <= {1'b0, lvl};
    repeat (n) @(posedge logicInputClock);
    tick(6);
    check(powerDownFlag, exp);
  endtask
  initial begin
    rst_n = 1'b0;
    powerOnActive = 1'b0;
    {writeLockout, mainBelowStandby} = 2'h0;
    {autoPowerDownEnable, strobeIdlePolarity} = 2'h0;
    {pmWrite, pmSelectC, mmWrite, flashProgramStart, flashEraseStart} = 5'h0;
    {flashOpDone, batteryRouteEnable, busControl1, busControl2} = 4'h0;
    writeHighByteStrobe = 1'b0;
    {pmWriteData, mmWriteData, lowAddress} = 24'h0;
    memMapConfig = 8'hFF;
    {mcDataIn, mcResetEq, mcPresetEq} = {16'hA5A5, 16'h0000, 16'h0000};
    {clkRun, strobeRun, strobeIdle, csActive} = 4'h9;
    // The supply monitor rises a few cycles into reset, so the
    // configuration count is seen to start from zero.
    tick(6);
    powerOnActive <= 1'b1;
    tick(14);
    check(resetMode & mcuIoInputMode & pldOutputsValid, 1'b1);
    check(primaryFlashSelect | ioSelect | dataPortOe, 1'b0);
    check(addressOutOe | peripheralOe, 1'b0);
    check(flashState === FL_READ, 1'b1);
    check(memoryMapRegister === 8'h7E, 1'b1);
    check(powerModeRegA === 8'h00 && powerModeRegC === 8'h00, 1'b1);
    check(mcOutputs === 16'h0000, 1'b1);
    tick(1);
    {rst_n, powerOnActive} <= 2'h2;
    tick(3);
    check(!resetMode & primaryFlashSelect & ioSelect, 1'b1);
    fl(3'h4);
    tick(1);
    check(flashState === FL_PROGRAM, 1'b1);
    wr(1'b0, 1'b0, 8'h30);
    wr(1'b0, 1'b1, 8'h7D);
    wr(1'b1, 1'b0, 8'hC3);
    lowAddress <= 8'h5A;
    {busControl1, busControl2, writeHighByteStrobe, strobeIdle} <= 4'hF;
    tick(3);
    check(andArrayClock | macrocellClockEnable, 1'b0);
    check(pldLowAddress === 8'h00, 1'b1);
    check(pldBusControl0 | pldBusControl1 | pldBusControl2, 1'b0);
    check(pldAddressStrobe | pldWriteHighByte, 1'b0);
    check(memoryMapRegister === 8'hC3, 1'b1);
    tick(1);
    rst_n <= 1'b0;
    tick(2);
    check(flashReadMode & pldOutputsValid, 1'b1);
    check(powerModeRegA === 8'h30 && powerModeRegC === 8'h7D, 1'b1);
    check(memoryMapRegister === 8'h7E, 1'b1);
    tick(1);
    rst_n <= 1'b1;
    tick(3);
    check(resetMode, 1'b0);
    writeLockout <= 1'b1;
    tick(6);
    fl(3'h2);
    tick(1);
    check(flashReadMode, 1'b1);
    writeLockout <= 1'b0;
    tick(6);
    fl(3'h2);
    tick(1);
    check(flashState === FL_ERASE, 1'b1);
    fl(3'h1);
    wr(1'b0, 1'b0, 8'h10);
    wr(1'b0, 1'b1, 8'h00);
    csActive <= 1'b0;
    tick(8);
    check(sramSelect | secondaryFlashSelect | primaryFlashSelect, 1'b0);
    check(ioSelect, 1'b1);
    check(pldLowAddress === 8'h5A, 1'b1);
    check(pldBusControl0 & pldBusControl1 & pldBusControl2, 1'b1);
    check(pldAddressStrobe & pldWriteHighByte, 1'b1);
    check(macrocellClockEnable & (mcOutputs === 16'hA5A5), 1'b1);
    idle(1'b0, 1'b1, 13, 1'b0);
    idle(1'b0, 1'b1, 17, 1'b1);
    check(busBlocked & mcuIoHold, 1'b1);
    check(ioSelect | sramSelect | dataPortOe | peripheralOe, 1'b0);
    check(powerModeRegA === 8'h10, 1'b1);
    csActive <= 1'b1;
    tick(8);
    check(powerDownFlag, 1'b0);
    csActive <= 1'b0;
    idle(1'b1, 1'b1, 20, 1'b0);
    strobeIdlePolarity <= 1'b1;
    idle(1'b1, 1'b1, 17, 1'b1);
    idle(1'b1, 1'b0, 20, 1'b0);
    {mainBelowStandby, batteryRouteEnable} <= 2'h3;
    tick(6);
    check(batteryOnIndicator & portEPin7Out & portEPin7Oe, 1'b1);
    summarize;
  end
endmodule
